// ===== common/mbr_pkg.sv
/*
 * Package of the boot, reset and timestamp control block: timing figures,
 * command codes, mode encodings, carrier structs and the state record.
 * Assumes a single 200 MHz clock with synchronous active-high reset.
 */
package mbr_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam longint CLK_HZ          = 200_000_000;
	localparam int     RST_MIN_US      = 125;
	localparam int     STROBE_MIN_US   = 125;
	localparam int     BOOT_TYP_S      = 3;
	localparam int     BOOT_MAX_S      = 5;
	localparam int     CAPTURE_MAX_MS  = 1;
	localparam int     RESPONSE_MAX_MS = 100;
	localparam longint LOW_BAUD        = 9600;
	localparam longint HIGH_BAUD       = 115200;

	localparam int unsigned BOOT_TYP_CYC =
		32'(BOOT_TYP_S * CLK_HZ);
	localparam int unsigned BOOT_MAX_CYC =
		32'(BOOT_MAX_S * CLK_HZ);
	localparam int unsigned LOW_BAUD_DIV  = 32'(CLK_HZ / LOW_BAUD);
	localparam logic [15:0] HIGH_BAUD_DIV = 16'(CLK_HZ / HIGH_BAUD);

	// power-on stretch after srst, in cycles
	localparam logic [7:0]  POR_CYC = 8'h40;

	// ---------------------------------------------------------------
	// serial command codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_DISCONNECT = 8'h07;
	localparam logic [7:0] CMD_RESET      = 8'h08;
	localparam logic [7:0] CMD_READ_TIME  = 8'h0c;

	// strap level per interface mode
	localparam logic MODE_LOW_SPEED  = 1'b0;
	localparam logic MODE_HIGH_SPEED = 1'b1;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} mbr_cmd_type;

	typedef enum logic [5:0] {
		ST_RESET     = 6'h01,
		ST_LOAD_IMG  = 6'h02,
		ST_LOAD_PRM  = 6'h04,
		ST_WAIT_BOOT = 6'h08,
		ST_BOOT_EVT  = 6'h10,
		ST_RUN       = 6'h20
	} mbr_state_type;

	typedef struct packed {
		mbr_state_type state;
		logic [1:0]    rstSync;
		logic [1:0]    strbSync;
		logic          strbDly;
		logic          strbArmed;
		logic [1:0]    hostSync;
		logic [1:0]    modeSync;
		logic [7:0]    porCnt;
		logic [31:0]   bootCnt;
		logic [15:0]   baudCnt;
		logic          baudTick;
		logic          highSpeed;
		logic          coreRstN;
		logic          serialReady;
		logic          nodeAccN;
		logic          bootEvtReq;
		logic          timeReq;
		logic          imgStart;
		logic          prmStart;
		logic [63:0]   stamp;
		logic          stampValid;
	} mbr_ctrl_type;

	// strobe edge detector starts at the pin's idle high level
	localparam mbr_ctrl_type CTRL_RST = '{
		state:    ST_RESET,
		strbSync: 2'b11,
		strbDly:  1'b1,
		nodeAccN: 1'b1,
		default:  '0
	};

endpackage

// ===== design/mbr_ctrl.sv
/*
 * Boot, reset, boot-event and timestamp control of a mesh node seen from
 * its host port. Assumes image and parameter loaders, a UART framer that
 * answers txAccept, and a network-time source, all on mclk.
 */
`timescale 1ns/1ps

// Function
// - built-in power-on stretch boots the node with no external reset.
// - node stays in reset while reset pin low; host holds 125 us.
// - after release, load application image, then parameters, then serial.
// - serial available typically 3 s, at most 5 s after power.
// - packet-accept handshake held high until the serial side boots.
// - boot event packet sent on boot under full host handshake.
// - serial reset command 0x08 resets the node.
// - time packet sent on serial read-time request or strobe.
// - strobe activation captures the timestamp within about 1 ms.
// - serial read-time capture may lag the request.
// - time packet starts within 100 ms of strobe negation.
// - strap low picks low-speed mode, high picks high-speed mode.
// - low-speed mode runs 8N, 9600 bps, packet flow control.
// - high-speed mode runs 8N, 115.2 kbps, byte flow control out.
// - after boot, accept handshake negated until joined and buffered.
// - strobe is active low, recognised on its falling edge.
module mbr_ctrl #(
	parameter int unsigned BOOT_TYP_CYC = mbr_pkg::BOOT_TYP_CYC,
	parameter int unsigned BOOT_MAX_CYC = mbr_pkg::BOOT_MAX_CYC,
	parameter int unsigned LOW_DIV      = mbr_pkg::LOW_BAUD_DIV
) (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                srst,
	// pins from the host board
	input  wire logic                rstPinN,
	input  wire logic                timeStrobeN,
	input  wire logic                modeStrap,
	input  wire logic                hostReadyN,
	// loaders
	output logic                     imgLoadStart,
	output logic                     paramLoadStart,
	input  wire logic                imgLoaded,
	input  wire logic                paramLoaded,
	// serial framer
	input  wire mbr_pkg::mbr_cmd_type rxCmd,
	input  wire logic                txAccept,
	output logic                     bootEventReq,
	output logic                     timePacketReq,
	output logic                     serialReady,
	output logic                     highSpeed,
	output logic                     baudTick,
	// network side
	input  wire logic                networkJoined,
	input  wire logic                bufferOk,
	input  wire logic [63:0]         netTime,
	output logic [63:0]              stamp,
	output logic                     stampValid,
	// node control
	output logic                     coreResetN,
	output logic                     nodeAcceptsPacketN
);

	mbr_pkg::mbr_ctrl_type st_r;
	mbr_pkg::mbr_ctrl_type st_nxt;

	logic strbFall;
	logic strbRise;
	logic inBoot;

	assign strbFall = st_r.strbDly & ~st_r.strbSync[1];
	assign strbRise = ~st_r.strbDly & st_r.strbSync[1];
	assign inBoot   = st_r.state == mbr_pkg::ST_LOAD_IMG
		|| st_r.state == mbr_pkg::ST_LOAD_PRM
		|| st_r.state == mbr_pkg::ST_WAIT_BOOT;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rstSync  = {st_r.rstSync[0], rstPinN};
		st_nxt.strbSync = {st_r.strbSync[0], timeStrobeN};
		st_nxt.hostSync = {st_r.hostSync[0], hostReadyN};
		st_nxt.modeSync = {st_r.modeSync[0], modeStrap};
		st_nxt.strbDly  = st_r.strbSync[1];
		st_nxt.imgStart   = 1'b0;
		st_nxt.prmStart   = 1'b0;
		st_nxt.stampValid = 1'b0;
		st_nxt.baudTick   = 1'b0;

		// bit-rate enable for the framer, per strapped mode
		if (!st_r.serialReady)
			st_nxt.baudCnt = '0;
		else if (st_r.baudCnt == '0)
		begin
			st_nxt.baudTick = 1'b1;
			if (st_r.highSpeed)
				st_nxt.baudCnt = mbr_pkg::HIGH_BAUD_DIV - 16'h0001;
			else
				st_nxt.baudCnt = 16'(LOW_DIV - 1);
		end
		else
			st_nxt.baudCnt = st_r.baudCnt - 16'h0001;

		if (inBoot && st_r.bootCnt != BOOT_MAX_CYC)
			st_nxt.bootCnt = st_r.bootCnt + 32'h0000_0001;

		unique case (st_r.state)
			mbr_pkg::ST_RESET:
			begin
				st_nxt.coreRstN    = 1'b0;
				st_nxt.serialReady = 1'b0;
				st_nxt.nodeAccN    = 1'b1;
				st_nxt.bootEvtReq  = 1'b0;
				st_nxt.timeReq     = 1'b0;
				st_nxt.strbArmed   = 1'b0;
				if (!st_r.rstSync[1])
					st_nxt.porCnt = '0;
				else if (st_r.porCnt == mbr_pkg::POR_CYC - 8'h01)
				begin
					st_nxt.state     = mbr_pkg::ST_LOAD_IMG;
					st_nxt.coreRstN  = 1'b1;
					st_nxt.imgStart  = 1'b1;
					st_nxt.bootCnt   = '0;
					st_nxt.highSpeed = st_r.modeSync[1]
						== mbr_pkg::MODE_HIGH_SPEED;
				end
				else
					st_nxt.porCnt = st_r.porCnt + 8'h01;
			end
			mbr_pkg::ST_LOAD_IMG:
				if (imgLoaded)
				begin
					st_nxt.state    = mbr_pkg::ST_LOAD_PRM;
					st_nxt.prmStart = 1'b1;
				end
			mbr_pkg::ST_LOAD_PRM:
				if (paramLoaded)
					st_nxt.state = mbr_pkg::ST_WAIT_BOOT;
			mbr_pkg::ST_WAIT_BOOT:
				if (st_r.bootCnt >= BOOT_TYP_CYC - 1)
				begin
					st_nxt.state       = mbr_pkg::ST_BOOT_EVT;
					st_nxt.serialReady = 1'b1;
				end
			mbr_pkg::ST_BOOT_EVT:
			begin
				// request only once the host shows it can receive
				if (!st_r.hostSync[1])
					st_nxt.bootEvtReq = 1'b1;
				if (st_r.bootEvtReq && txAccept)
				begin
					st_nxt.bootEvtReq = 1'b0;
					st_nxt.state      = mbr_pkg::ST_RUN;
				end
			end
			mbr_pkg::ST_RUN:
			begin
				st_nxt.nodeAccN = !(networkJoined && bufferOk);
				if (txAccept)
					st_nxt.timeReq = 1'b0;
				if (strbFall)
				begin
					st_nxt.stamp      = netTime;
					st_nxt.stampValid = 1'b1;
					st_nxt.strbArmed  = 1'b1;
				end
				if (strbRise && st_r.strbArmed)
				begin
					st_nxt.timeReq   = 1'b1;
					st_nxt.strbArmed = 1'b0;
				end
				if (rxCmd.valid)
				begin
					if (rxCmd.code == mbr_pkg::CMD_READ_TIME)
					begin
						st_nxt.stamp      = netTime;
						st_nxt.stampValid = 1'b1;
						st_nxt.timeReq    = 1'b1;
					end
					if (rxCmd.code == mbr_pkg::CMD_RESET
						|| rxCmd.code == mbr_pkg::CMD_DISCONNECT)
					begin
						st_nxt.state  = mbr_pkg::ST_RESET;
						st_nxt.porCnt = '0;
					end
				end
			end
		endcase

		// boot may not overrun its longest time
		if (inBoot && st_r.bootCnt == BOOT_MAX_CYC - 1)
		begin
			st_nxt.state       = mbr_pkg::ST_BOOT_EVT;
			st_nxt.serialReady = 1'b1;
		end

		if (!st_r.rstSync[1])
		begin
			st_nxt.state  = mbr_pkg::ST_RESET;
			st_nxt.porCnt = '0;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (srst)
			st_r <= mbr_pkg::CTRL_RST;
		else
			st_r <= st_nxt;
	end

	assign imgLoadStart       = st_r.imgStart;
	assign paramLoadStart     = st_r.prmStart;
	assign bootEventReq       = st_r.bootEvtReq;
	assign timePacketReq      = st_r.timeReq;
	assign serialReady        = st_r.serialReady;
	assign highSpeed          = st_r.highSpeed;
	assign baudTick           = st_r.baudTick;
	assign stamp              = st_r.stamp;
	assign stampValid         = st_r.stampValid;
	assign coreResetN         = st_r.coreRstN;
	assign nodeAcceptsPacketN = st_r.nodeAccN;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_por_done;
		st_r.state == mbr_pkg::ST_RESET && st_r.rstSync[1]
			&& st_r.porCnt == mbr_pkg::POR_CYC - 8'h01;
	endsequence

	// armed by a falling edge, then released while still running
	sequence s_strobe_cycle;
		st_r.strbArmed && st_r.state == mbr_pkg::ST_RUN
			##1 strbRise && st_r.state == mbr_pkg::ST_RUN;
	endsequence

	a_por_boot: assert property (
		s_por_done |=> st_r.state == mbr_pkg::ST_LOAD_IMG
			&& imgLoadStart && coreResetN ##1 !imgLoadStart)
		else $error("power-on stretch did not start boot");

	a_pin_reset: assert property (
		!st_r.rstSync[1] |=> st_r.state == mbr_pkg::ST_RESET
			##1 !coreResetN)
		else $error("reset pin low did not hold reset");

	a_boot_order: assert property (
		st_r.state == mbr_pkg::ST_LOAD_IMG && imgLoaded
			&& st_r.rstSync[1] && st_r.bootCnt < BOOT_MAX_CYC - 1
			|=> st_r.state == mbr_pkg::ST_LOAD_PRM && paramLoadStart)
		else $error("parameters not loaded after image");

	a_boot_max: assert property (
		inBoot && st_r.rstSync[1] && st_r.bootCnt == BOOT_MAX_CYC - 1
			|=> serialReady && st_r.state == mbr_pkg::ST_BOOT_EVT)
		else $error("serial not available at longest boot time");

	a_cts_boot: assert property (
		$past(st_r.state) != mbr_pkg::ST_RUN |-> nodeAcceptsPacketN)
		else $error("accept handshake active before boot done");

	a_boot_event: assert property (
		st_r.state == mbr_pkg::ST_BOOT_EVT && !st_r.hostSync[1]
			&& st_r.rstSync[1] && !(bootEventReq && txAccept)
			|=> bootEventReq
			until_with (txAccept || !st_r.rstSync[1]))
		else $error("boot event not requested under handshake");

	a_cmd_reset: assert property (
		st_r.state == mbr_pkg::ST_RUN && rxCmd.valid
			&& rxCmd.code == mbr_pkg::CMD_RESET
			|=> st_r.state == mbr_pkg::ST_RESET ##1 !coreResetN)
		else $error("reset command ignored");

	a_strobe_capture: assert property (
		strbFall && st_r.state == mbr_pkg::ST_RUN
			|=> stampValid && stamp == $past(netTime))
		else $error("strobe fall did not capture time");

	a_time_packet: assert property (
		s_strobe_cycle |=> timePacketReq)
		else $error("no time packet after strobe negation");

	a_cts_join: assert property (
		st_r.state == mbr_pkg::ST_RUN && !networkJoined
			&& st_r.rstSync[1] |=> nodeAcceptsPacketN)
		else $error("accept handshake active while not joined");

	a_mode_rate: assert property (
		baudTick && highSpeed |=> !baudTick [*8])
		else $error("bit-rate enable too fast");

endmodule // mbr_ctrl

// ===== sim/mbr_host_model.sv
/*
 * Host-side partner: answers load starts and packet requests.
 * Assumes the block under test runs on the same mclk.
 */
`timescale 1ns/1ps
module mbr_host_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic srst,
	// bench controls
	input  wire logic slow,
	input  wire logic hostBusy,
	input  wire logic stallPrm,
	// from the block
	input  wire logic imgLoadStart,
	input  wire logic paramLoadStart,
	input  wire logic bootEventReq,
	input  wire logic timePacketReq,
	// to the block
	output logic      imgLoaded,
	output logic      paramLoaded,
	output logic      hostReadyN,
	output logic      txAccept
);
	logic [3:0] waitCnt;

	always_ff @(posedge mclk)
	begin
		imgLoaded   <= imgLoadStart & ~srst;
		// a stalled parameter loader never answers
		paramLoaded <= paramLoadStart & ~srst & ~stallPrm;
		hostReadyN  <= hostBusy | srst;
		if (srst || txAccept || !(bootEventReq || timePacketReq))
		begin
			waitCnt  <= 4'h0;
			txAccept <= 1'b0;
		end
		else
		begin
			waitCnt  <= waitCnt + 4'h1;
			// one-cycle accept, prompt or slow
			txAccept <= (waitCnt == (slow ? 4'hc : 4'h1));
		end
	end
endmodule // mbr_host_model

// ===== sim/mbr_ctrl_bench.sv
/*
 * Self-checking bench of the boot, reset and timestamp control block.
 * Assumes mbr_pkg and the host partner model; short boot counts.
 */
`timescale 1ns/1ps
module mbr_ctrl_bench;
	logic        mclk = 0, srst = 1, rstPinN = 1, timeStrobeN = 1;
	logic        modeStrap = 0, hostBusy = 0, slow = 0, stallPrm = 0;
	logic        networkJoined = 0, bufferOk = 0;
	logic [63:0] netTime = '0, stamp;
	logic        imgLoaded, paramLoaded, hostReadyN, txAccept;
	logic        imgLoadStart, paramLoadStart, bootEventReq;
	logic        timePacketReq, serialReady, highSpeed, baudTick;
	logic        stampValid, coreResetN, nodeAcceptsPacketN;
	int          errTotal = 0, checks = 0;
	mbr_pkg::mbr_cmd_type rxCmd = '0;

	always #2.5 mclk = ~mclk;
	always @(negedge mclk) netTime <= netTime + 64'h1;

	mbr_ctrl #(.BOOT_TYP_CYC(200), .BOOT_MAX_CYC(400), .LOW_DIV(50)) dut_u (
		.mclk, .srst, .rstPinN, .timeStrobeN, .modeStrap, .hostReadyN,
		.imgLoadStart, .paramLoadStart, .imgLoaded, .paramLoaded,
		.rxCmd, .txAccept, .bootEventReq, .timePacketReq, .serialReady,
		.highSpeed, .baudTick, .networkJoined, .bufferOk, .netTime,
		.stamp, .stampValid, .coreResetN, .nodeAcceptsPacketN);

	mbr_host_model host_u (
		.mclk, .srst, .slow, .hostBusy, .stallPrm, .imgLoadStart,
		.paramLoadStart, .bootEventReq, .timePacketReq, .imgLoaded,
		.paramLoaded,
		.hostReadyN, .txAccept);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task summarize;
		$display("checks=%0d errors=%0d", checks, errTotal);
		if (errTotal == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			errTotal++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// bounded wait on a level, judged at falling edges
	task automatic waitFor(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim)
		begin
			@(negedge mclk);
			n++;
		end
		chk(s, v);
		if (s !== v)
			summarize();
	endtask

	task sendCmd(input logic [7:0] code);
		rxCmd = '{valid: 1'b1, code: code};
		@(negedge mclk);
		rxCmd = '0;
	endtask

	task bootUp(input logic strap, input logic busy);
		int n;
		logic imgSeen;
		n = 0;
		imgSeen = 0;
		hostBusy = busy;
		while (serialReady !== 1'b1 && n < 1000)
		begin
			@(negedge mclk);
			n++;
			if (imgLoadStart === 1'b1)
				imgSeen = 1;
			if (paramLoadStart === 1'b1)
				chk(imgSeen, 1);
			chk(nodeAcceptsPacketN, 1);
		end
		chk(n < 480, 1);
		chk(highSpeed, strap);
		if (busy)
		begin
			repeat (30) @(negedge mclk);
			chk(bootEventReq, 0);
			hostBusy = 0;
		end
		waitFor(bootEventReq, 1, 20);
		waitFor(bootEventReq, 0, 40);
		waitFor(baudTick, 1, 2000);
		@(negedge mclk);
		n = 1;
		while (baudTick !== 1'b1 && n < 2000)
		begin
			@(negedge mclk);
			n++;
		end
		chk(n, strap ? mbr_pkg::HIGH_BAUD_DIV : 50);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task strobe;
		slow = 1;
		timeStrobeN = 0;
		waitFor(stampValid, 1, 10);
		chk(netTime - stamp <= 64'h8, 1);
		repeat (25000) @(negedge mclk);
		chk(timePacketReq, 0);
		timeStrobeN = 1;
		waitFor(timePacketReq, 1, 10);
		waitFor(timePacketReq, 0, 40);
		slow = 0;
	endtask

	task readTime;
		logic [63:0] t0;
		t0 = netTime;
		sendCmd(mbr_pkg::CMD_READ_TIME);
		waitFor(stampValid, 1, 10);
		chk(stamp - t0 <= 64'h8, 1);
		waitFor(timePacketReq, 1, 10);
		waitFor(timePacketReq, 0, 20);
	endtask

	task acceptLevels;
		for (int i = 0; i < 4; i++)
		begin
			networkJoined = i[1];
			bufferOk = i[0];
			repeat (3) @(negedge mclk);
			chk(nodeAcceptsPacketN, !(i[1] && i[0]));
		end
	endtask

	task cmdReset(input logic [7:0] code);
		sendCmd(code);
		waitFor(coreResetN, 0, 10);
		repeat (2) @(negedge mclk);
		bootUp(0, 0);
	endtask

	task pinReset;
		rstPinN = 0;
		waitFor(coreResetN, 0, 10);
		repeat (25000) @(negedge mclk);
		chk(coreResetN, 0);
		modeStrap = 1;
		rstPinN = 1;
		bootUp(1, 1);
	endtask

	initial
	begin
		repeat (10) @(negedge mclk);
		srst = 0;
		bootUp(0, 0);
		strobe();
		readTime();
		acceptLevels();
		cmdReset(mbr_pkg::CMD_DISCONNECT);
		// parameters never load: boot must end at its longest time
		stallPrm = 1;
		cmdReset(mbr_pkg::CMD_RESET);
		stallPrm = 0;
		pinReset();
		summarize();
	end
endmodule // mbr_ctrl_bench
